/* File: ats_sequencer.sv */
// Converter sequencer: control sets, series, result bank and touch readout
//
// Notes on behaviour
// - A finished series of eight lands in one bank of eight results, four readable at a time.
// - Pulse output follows conversions for a span of 4 or 8, chosen by software.
// - Thermistor bias is on only while a conversion series runs.
// - Channel seven switches between die temperature and accessory identification.
// - Pen mode biases one plate, grounds the other, interrupts on contact, no conversion.
// - Contact resistance mode drives X against Y and converts the current.
// - Plate mode drives one plate, floats the other, converts driven plate current.
// - Position mode reads X through Y, Y through X, plus contact resistance.
// - Touch slots 0-2 X plate, 3-5 Y plate, 6-7 contact; stored per slot.
// - Each 24-bit result register read returns two 10-bit results.
// - Two control sets, own and secondary, allow a queued second request.
// - Control write with bit 23 set goes to the secondary set.
// - Bit 23 reads zero; secondary set is not readable.
// - Results come back through two result registers apart from control.
// - One converter core serves all requests, one series after another.
// - A series starts on external trigger rising edge or a written command.
// - First conversion waits 0 to 8 ms; gaps may equal that delay.
// - With trigger-ignore set every external trigger transition is disregarded.
// - Series completion is signalled to the set that started it.
//
// The strobed register port and the register offsets were left to the implementer.
`default_nettype none
module ats_sequencer #(
   parameter int DELAY_UNIT_CYC = ats_pkg::DELAY_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [23:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [23:0] rdata,
   output logic conv_start,
   output logic [3:0] conv_chan,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   input wire logic external_convert_trigger,
   input wire logic touch_pen_contact,
   output logic conversion_pulse_out,
   output logic thermistor_bias_en,
   output logic temp_or_id_select,
   output logic touch_x_drive,
   output logic touch_y_drive,
   output logic touch_contact_drive,
   output logic touch_pen_bias,
   output logic pen_irq,
   output logic series_done_primary,
   output logic series_done_secondary
);
   typedef struct packed {
      ats_pkg::ats_state_e state;
      logic [2:0] slot;
      logic owner;
      logic pend_p;
      logic pend_s;
      logic [23:0] cfg_p;
      logic [23:0] cfg_s;
      logic [23:0] act;
      logic [7:0][9:0] res;
      logic [23:0] rdata;
      logic conv_start;
      logic [3:0] conv_chan;
      logic pulse;
      logic therm;
      logic ch7;
      logic [2:0] drv;
      logic penb;
      logic pen_irq;
      logic done_p;
      logic done_s;
      logic tmr_go;
      logic [3:0] tmr_units;
      logic [2:0] trg;
      logic [2:0] pen;
   } ats_seq_s;

   ats_seq_s q;
   ats_seq_s d;
   logic [2:0] base;

   ats_tmr_if tif ();

   ats_delay_timer #(.UNIT_CYC(DELAY_UNIT_CYC)) u_timer (
      .clk(clk),
      .rst(rst),
      .t(tif.tmr)
   );

   assign tif.go = q.tmr_go;
   assign tif.units = q.tmr_units;
   assign rdata = q.rdata;
   assign conv_start = q.conv_start;
   assign conv_chan = q.conv_chan;
   assign conversion_pulse_out = q.pulse;
   assign thermistor_bias_en = q.therm;
   assign temp_or_id_select = q.ch7;
   assign touch_x_drive = q.drv[2];
   assign touch_y_drive = q.drv[1];
   assign touch_contact_drive = q.drv[0];
   assign touch_pen_bias = q.penb;
   assign pen_irq = q.pen_irq;
   assign series_done_primary = q.done_p;
   assign series_done_secondary = q.done_s;

   // Delay in milliseconds, codes above the maximum are clamped
   function automatic logic [3:0] dly_of(input logic [23:0] c);
      logic [3:0] v;
      v = c[ats_pkg::B_DLY_HI:ats_pkg::B_DLY_LO];
      dly_of = (v > ats_pkg::DELAY_MAX) ? ats_pkg::DELAY_MAX : v;
   endfunction

   function automatic logic is_touch(input logic [23:0] c);
      logic [1:0] m;
      m = c[ats_pkg::B_MODE_HI:ats_pkg::B_MODE_LO];
      is_touch = (m == ats_pkg::M_RESIST) || (m == ats_pkg::M_POSITION);
   endfunction

   // Plate drive per slot: X plate, Y plate, X against Y
   function automatic logic [2:0] drv_of(input logic [23:0] c, input logic [2:0] s);
      drv_of = 3'h0;
      if (is_touch(c)) begin
         if (s < ats_pkg::SLOT_Y_FIRST) begin
            drv_of = 3'h4;
         end else if (s < ats_pkg::SLOT_C_FIRST) begin
            drv_of = 3'h2;
         end else begin
            drv_of = 3'h1;
         end
      end
   endfunction

   // Converter channel per slot
   function automatic logic [3:0] chan_of(input logic [23:0] c, input logic [2:0] s);
      logic [1:0] m;
      m = c[ats_pkg::B_MODE_HI:ats_pkg::B_MODE_LO];
      if (m == ats_pkg::M_RESIST) begin
         if (s < ats_pkg::SLOT_Y_FIRST) begin
            chan_of = ats_pkg::CH_XA;
         end else if (s < ats_pkg::SLOT_C_FIRST) begin
            chan_of = ats_pkg::CH_YA;
         end else begin
            chan_of = ats_pkg::CH_XB;
         end
      end else if (m == ats_pkg::M_POSITION) begin
         if (s < ats_pkg::SLOT_Y_FIRST) begin
            chan_of = ats_pkg::CH_YA;
         end else if (s < ats_pkg::SLOT_C_FIRST) begin
            chan_of = ats_pkg::CH_XA;
         end else begin
            chan_of = ats_pkg::CH_XB;
         end
      end else if (c[ats_pkg::B_SINGLE]) begin
         chan_of = {c[ats_pkg::B_GROUP], c[ats_pkg::B_CHAN_HI:ats_pkg::B_CHAN_LO]};
      end else begin
         chan_of = {c[ats_pkg::B_GROUP], s};
      end
   endfunction

   // Result half picks slots 0-3 or 4-7 for the two result registers
   assign base = {q.cfg_p[ats_pkg::B_RES_HALF], 2'b00};

   always_comb begin
      d = q;
      d.conv_start = 1'b0;
      d.pen_irq = 1'b0;
      d.done_p = 1'b0;
      d.done_s = 1'b0;
      d.tmr_go = 1'b0;
      d.trg = {q.trg[1:0], external_convert_trigger};
      d.pen = {q.pen[1:0], touch_pen_contact};

      // Read path, data stand one cycle after the strobe
      d.rdata = 24'h000000;
      if (rd_en) begin
         case (addr)
            ats_pkg::A_CTRL: begin
               d.rdata = {1'b0, q.cfg_p[22:1], 1'b0};
            end
            ats_pkg::A_STATUS: begin
               d.rdata = {16'h0000, q.pen[1], q.slot, q.pend_s, q.pend_p, q.owner,
                          q.state != ats_pkg::S_IDLE};
            end
            ats_pkg::A_RES_A: begin
               d.rdata = {2'b00, q.res[3'(base + 3'h1)], 2'b00, q.res[base]};
            end
            ats_pkg::A_RES_B: begin
               d.rdata = {2'b00, q.res[3'(base + 3'h3)], 2'b00,
                          q.res[3'(base + 3'h2)]};
            end
            default: begin
               d.rdata = 24'h000000;
            end
         endcase
      end

      // Series sequencing on the one shared core
      case (q.state)
         ats_pkg::S_IDLE: begin
            if (q.pend_p || q.pend_s) begin
               d.owner = !q.pend_p;
               d.act = q.pend_p ? q.cfg_p : q.cfg_s;
               if (q.pend_p) begin
                  d.pend_p = 1'b0;
               end else begin
                  d.pend_s = 1'b0;
               end
               d.state = ats_pkg::S_WAIT;
               d.slot = 3'h0;
               d.tmr_go = 1'b1;
               d.tmr_units = dly_of(q.pend_p ? q.cfg_p : q.cfg_s);
               d.therm = 1'b1;
               d.drv = drv_of(q.pend_p ? q.cfg_p : q.cfg_s, 3'h0);
            end
         end
         ats_pkg::S_WAIT: begin
            if (tif.expired) begin
               d.state = ats_pkg::S_CONV;
               d.conv_start = 1'b1;
               d.conv_chan = chan_of(q.act, q.slot);
               if (q.act[ats_pkg::B_PULSE_EN] &&
                   (q.act[ats_pkg::B_SPAN8] || q.slot <= ats_pkg::SLOT_LAST4)) begin
                  d.pulse = 1'b1;
               end
            end
         end
         ats_pkg::S_CONV: begin
            if (conv_done) begin
               d.res[q.slot] = conv_data;
               if (q.slot == (q.act[ats_pkg::B_SPAN8] ? ats_pkg::SLOT_LAST
                                                      : ats_pkg::SLOT_LAST4)) begin
                  d.pulse = 1'b0;
               end
               if (q.slot == ats_pkg::SLOT_LAST) begin
                  d.state = ats_pkg::S_IDLE;
                  d.therm = 1'b0;
                  d.drv = 3'h0;
                  d.done_p = !q.owner;
                  d.done_s = q.owner;
               end else begin
                  d.slot = q.slot + 3'h1;
                  d.drv = drv_of(q.act, q.slot + 3'h1);
                  if (q.act[ats_pkg::B_GAP_EQ]) begin
                     d.state = ats_pkg::S_WAIT;
                     d.tmr_go = 1'b1;
                     d.tmr_units = dly_of(q.act);
                  end else begin
                     d.conv_start = 1'b1;
                     d.conv_chan = chan_of(q.act, q.slot + 3'h1);
                     if (q.act[ats_pkg::B_PULSE_EN] &&
                         (q.act[ats_pkg::B_SPAN8] || q.slot < ats_pkg::SLOT_LAST4)) begin
                        d.pulse = 1'b1;
                     end
                  end
               end
            end
         end
         default: begin
            d.state = ats_pkg::S_IDLE;
         end
      endcase

      // Requests come after the sequencer so a new start is never lost
      if (wr_en && addr == ats_pkg::A_CTRL) begin
         if (wdata[ats_pkg::B_SEC_SEL]) begin
            d.cfg_s = wdata;
            if (wdata[ats_pkg::B_START]) begin
               d.pend_s = 1'b1;
            end
         end else begin
            d.cfg_p = wdata;
            if (wdata[ats_pkg::B_START]) begin
               d.pend_p = 1'b1;
            end
         end
      end
      if (q.trg[1] && !q.trg[2] && !q.cfg_p[ats_pkg::B_TRIG_IGN]) begin
         d.pend_p = 1'b1;
      end

      // Channel seven source follows the running set, else the primary one
      d.ch7 = (q.state == ats_pkg::S_IDLE) ? q.cfg_p[ats_pkg::B_CH7_ID]
                                           : q.act[ats_pkg::B_CH7_ID];

      // Pen detect works without the converter, only while no series runs
      d.penb = (q.cfg_p[ats_pkg::B_MODE_HI:ats_pkg::B_MODE_LO] == ats_pkg::M_PEN) &&
               (d.state == ats_pkg::S_IDLE);
      if (q.penb && q.pen[1] && !q.pen[2]) begin
         d.pen_irq = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         q.cfg_p <= ats_pkg::CFG_RST;
         q.cfg_s <= ats_pkg::CFG_RST;
      end else begin
         q <= d;
      end
   end
endmodule // ats_sequencer
`default_nettype wire

/* File: ats_pkg.sv */
// Constants shared by the converter sequencer and its delay timer
`default_nettype none
package ats_pkg;
   localparam int DW = 24;
   localparam int RW = 10;
   // Register offsets
   localparam logic [2:0] A_CTRL = 3'h0;
   localparam logic [2:0] A_STATUS = 3'h1;
   localparam logic [2:0] A_RES_A = 3'h2;
   localparam logic [2:0] A_RES_B = 3'h3;
   // Control word fields
   localparam int B_START = 0;
   localparam int B_MODE_LO = 1;
   localparam int B_MODE_HI = 2;
   localparam int B_TRIG_IGN = 3;
   localparam int B_DLY_LO = 4;
   localparam int B_DLY_HI = 7;
   localparam int B_GAP_EQ = 8;
   localparam int B_PULSE_EN = 9;
   localparam int B_SPAN8 = 10;
   localparam int B_CH7_ID = 11;
   localparam int B_GROUP = 12;
   localparam int B_SINGLE = 13;
   localparam int B_CHAN_LO = 14;
   localparam int B_CHAN_HI = 16;
   localparam int B_RES_HALF = 17;
   localparam int B_SEC_SEL = 23;
   localparam logic [23:0] CFG_RST = 24'h000000;
   // Touch readout modes
   localparam logic [1:0] M_OFF = 2'h0;
   localparam logic [1:0] M_PEN = 2'h1;
   localparam logic [1:0] M_RESIST = 2'h2;
   localparam logic [1:0] M_POSITION = 2'h3;
   // Converter channels of the touch plates
   localparam logic [3:0] CH_XA = 4'hc;
   localparam logic [3:0] CH_XB = 4'hd;
   localparam logic [3:0] CH_YA = 4'he;
   // Slot boundaries of a touch series
   localparam logic [2:0] SLOT_Y_FIRST = 3'h3;
   localparam logic [2:0] SLOT_C_FIRST = 3'h6;
   localparam logic [2:0] SLOT_LAST = 3'h7;
   localparam logic [2:0] SLOT_LAST4 = 3'h3;
   // Start delay, counted in whole milliseconds
   localparam int CLK_MHZ = 40;
   localparam int DELAY_UNIT_US = 1000;
   localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
   localparam logic [3:0] DELAY_MAX = 4'h8;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_WAIT = 2'b01,
      S_CONV = 2'b11
   } ats_state_e;
endpackage
`default_nettype wire

/* File: ats_tmr_if.sv */
// Handshake between the sequencer and its delay timer
`default_nettype none
interface ats_tmr_if;
   logic go;
   logic [3:0] units;
   logic expired;
   modport ctl (output go, output units, input expired);
   modport tmr (input go, input units, output expired);
endinterface
`default_nettype wire

/* File: ats_delay_timer.sv */
// Millisecond delay timer that paces the conversion series
`default_nettype none
module ats_delay_timer #(
   parameter int UNIT_CYC = ats_pkg::DELAY_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   ats_tmr_if.tmr t
);
   typedef struct packed {
      logic [15:0] pre;
      logic [3:0] left;
      logic run;
      logic expired;
   } ats_tmr_s;

   ats_tmr_s q;
   ats_tmr_s d;

   assign t.expired = q.expired;

   always_comb begin
      d = q;
      d.expired = 1'b0;
      if (t.go) begin
         d.pre = 16'h0000;
         d.left = t.units;
         d.run = 1'b1;
      end else if (q.run) begin
         if (q.left == 4'h0) begin
            d.run = 1'b0;
            d.expired = 1'b1;
         end else if (q.pre == 16'(UNIT_CYC - 1)) begin
            d.pre = 16'h0000;
            d.left = q.left - 4'h1;
         end else begin
            d.pre = q.pre + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // ats_delay_timer
`default_nettype wire

/* File: ats_core_model.sv */
// Converter core model: answers each request after a short or long latency
`default_nettype none
module ats_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic conv_start,
   input wire logic [3:0] conv_chan,
   output logic conv_done,
   output logic [9:0] conv_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   logic [9:0] val_q;
   always_ff @(posedge clk) begin
      conv_done <= 1'b0;
      if (rst) begin
         cnt_q <= 4'h0;
         val_q <= 10'h000;
      end else if (conv_start) begin
         cnt_q <= slow ? 4'h9 : 4'h2;
         val_q <= {2'h2, conv_chan, 4'h5};
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
         conv_done <= cnt_q == 4'h1;
      end
   end
   // Outside the done cycle the data lines show the inverse of the value latched at the last request
   assign conv_data = conv_done ? val_q : ~val_q;
endmodule // ats_core_model
`default_nettype wire

/* File: ats_sequencer_chk.sv */
// Assertions on the converter sequencer ports
`default_nettype none
module ats_sequencer_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic rd_en,
   input wire logic [23:0] rdata,
   input wire logic conv_start,
   input wire logic conversion_pulse_out,
   input wire logic thermistor_bias_en,
   input wire logic touch_x_drive,
   input wire logic touch_y_drive,
   input wire logic touch_contact_drive,
   input wire logic touch_pen_bias,
   input wire logic pen_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   conv_gap_a: assert property (conv_start |=> !conv_start [*2])
      else $error("conversion requests too close");
   bias_conv_a: assert property (conv_start |-> thermistor_bias_en)
      else $error("bias off during conversion");
   pulse_idle_a: assert property (!thermistor_bias_en |-> !conversion_pulse_out)
      else $error("pulse outside series");
   pulse_rise_a: assert property ($rose(conversion_pulse_out) |-> $past(conv_start) || conv_start)
      else $error("pulse not in step");
   pen_irq_a: assert property (pen_irq |-> $past(touch_pen_bias))
      else $error("pen interrupt without bias");
   pen_quiet_a: assert property (touch_pen_bias |-> !thermistor_bias_en)
      else $error("pen bias during series");
   sec_read_a: assert property (rd_en && addr == ats_pkg::A_CTRL |=> rdata[23] == 1'b0)
      else $error("select bit read back");
   plate_drive_a: assert property ($onehot0({touch_x_drive, touch_y_drive, touch_contact_drive}))
      else $error("plate drives overlap");
   drive_idle_a: assert property (!thermistor_bias_en |-> !(touch_x_drive || touch_y_drive || touch_contact_drive))
      else $error("plate driven outside series");
endmodule // ats_sequencer_chk
bind ats_sequencer ats_sequencer_chk ats_sequencer_chk_i (.clk(clk), .rst(rst), .addr(addr),
   .rd_en(rd_en), .rdata(rdata), .conv_start(conv_start),
   .conversion_pulse_out(conversion_pulse_out), .thermistor_bias_en(thermistor_bias_en),
   .touch_x_drive(touch_x_drive), .touch_y_drive(touch_y_drive),
   .touch_contact_drive(touch_contact_drive), .touch_pen_bias(touch_pen_bias), .pen_irq(pen_irq));
`default_nettype wire

/* File: tb_ats_sequencer.sv */
// Self-checking bench for the converter sequencer
`default_nettype none
module tb_ats_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [23:0] wdata = 24'h000000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic trig = 1'b0;
   logic pen = 1'b0;
   logic slow = 1'b0;
   logic [23:0] rdata;
   logic [3:0] chan;
   logic [9:0] data;
   logic start, done, pulse, therm, ch7, pbias, pirq, done_p, done_s, xd, yd, cd;
   int bad_count = 0;
   int n_compared = 0;
   int cycles = 0;
   int pulses = 0;
   int dones = 0;
   int irqs = 0;
   int plates = 0;
   always #12.5 clk = ~clk;
   ats_sequencer #(.DELAY_UNIT_CYC(4)) ats_sequencer_i (.clk(clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .conv_start(start),
      .conv_chan(chan), .conv_done(done), .conv_data(data), .external_convert_trigger(trig),
      .touch_pen_contact(pen), .conversion_pulse_out(pulse), .thermistor_bias_en(therm),
      .temp_or_id_select(ch7), .touch_x_drive(xd), .touch_y_drive(yd), .touch_contact_drive(cd),
      .touch_pen_bias(pbias), .pen_irq(pirq), .series_done_primary(done_p),
      .series_done_secondary(done_s));
   ats_core_model ats_core_model_i (.clk(clk), .rst(rst), .slow(slow), .conv_start(start),
      .conv_chan(chan), .conv_done(done), .conv_data(data));
   task automatic finish_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      pulses <= pulses + int'(done && pulse);
      dones <= dones + int'(done_p || done_s);
      irqs <= irqs + int'(pirq);
      // Plate drive seen at each conversion request: X in units, Y in 16s, contact in 256s
      plates <= plates + (start ? (xd ? 1 : (yd ? 16 : (cd ? 256 : 0))) : 0);
      if (cycles == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [23:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [23:0] exp);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rdata, exp);
      @(posedge clk);
   endtask
   task automatic wait_done(input logic sec);
      int n;
      n = 0;
      while (!(sec ? done_s : done_p) && n < 900) begin
         @(posedge clk);
         n++;
      end
      chk(sec ? done_s : done_p, 24'h000001);
      @(posedge clk);
   endtask
   // Channel expected in slot s of a series in touch mode m, or group g in mode off
   function automatic logic [3:0] cexp(logic [1:0] m, logic g, logic [2:0] s);
      if (m == ats_pkg::M_OFF) return {g, s};
      if (s >= ats_pkg::SLOT_C_FIRST) return ats_pkg::CH_XB;
      if ((s < ats_pkg::SLOT_Y_FIRST) == (m == ats_pkg::M_RESIST)) return ats_pkg::CH_XA;
      return ats_pkg::CH_YA;
   endfunction
   function automatic logic [23:0] pair(logic [1:0] m, logic g, logic [2:0] s);
      return {4'h2, cexp(m, g, s + 3'h1), 4'h5, 4'h2, cexp(m, g, s), 4'h5};
   endfunction
   initial begin
      int p0;
      int d0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(3'h0, 24'h000000);
      rd(3'h1, 24'h000000);
      wr(3'h5, 24'hffffff);
      rd(3'h5, 24'h000000);
      // One-unit start delay and gaps (4 cycles in this bench), pulse over four, id voltage on channel seven
      p0 = pulses;
      wr(3'h0, 24'h000b11);
      rd(3'h0, 24'h000b10);
      chk(therm, 24'h000001);
      wait_done(1'b0);
      chk(therm, 24'h000000);
      chk(24'(pulses - p0), 24'h000004);
      chk(ch7, 24'h000001);
      rd(3'h2, pair(2'h0, 1'b0, 3'h0));
      rd(3'h3, pair(2'h0, 1'b0, 3'h2));
      wr(3'h0, 24'h020b10);
      rd(3'h2, pair(2'h0, 1'b0, 3'h4));
      rd(3'h3, pair(2'h0, 1'b0, 3'h6));
      // Secondary request queued behind a primary one on a slow core
      slow <= 1'b1;
      p0 = pulses;
      d0 = dones;
      wr(3'h0, 24'h000601);
      wr(3'h0, 24'h801001);
      rd(3'h0, 24'h000600);
      wait_done(1'b0);
      chk(24'(pulses - p0), 24'h000008);
      wait_done(1'b1);
      chk(24'(dones - d0), 24'h000002);
      rd(3'h2, pair(2'h0, 1'b1, 3'h0));
      slow <= 1'b0;
      for (int m = 2; m < 4; m++) begin
         p0 = plates;
         wr(3'h0, {21'h000000, m[1:0], 1'b1});
         wait_done(1'b0);
         chk(24'(plates - p0), 24'h000233);
         rd(3'h2, pair(m[1:0], 1'b0, 3'h0));
         rd(3'h3, pair(m[1:0], 1'b0, 3'h2));
         wr(3'h0, {4'h0, 4'h2, 13'h0000, m[1:0], 1'b0});
         rd(3'h2, pair(m[1:0], 1'b0, 3'h4));
         rd(3'h3, pair(m[1:0], 1'b0, 3'h6));
      end
      d0 = dones;
      wr(3'h0, 24'h000008);
      trig <= 1'b1;
      repeat (60) @(posedge clk);
      chk(24'(dones - d0), 24'h000000);
      trig <= 1'b0;
      wr(3'h0, 24'h000000);
      repeat (4) @(posedge clk);
      trig <= 1'b1;
      wait_done(1'b0);
      // Pen detect in idle: bias on, one interrupt on contact
      d0 = irqs;
      wr(3'h0, 24'h000002);
      @(posedge clk);
      chk(pbias, 24'h000001);
      pen <= 1'b1;
      repeat (8) @(posedge clk);
      chk(24'(irqs - d0), 24'h000001);
      finish_test();
   end
endmodule // tb_ats_sequencer
`default_nettype wire
